// *** hw/tiss_pkg.sv ***
// tiss_pkg: register indices, field positions and reset values shared by
// the timer input source select block.
// assumes a 32-bit classic wishbone bus with byte addresses.
package tiss_pkg;
  // register indices; byte address is four times the index
  localparam logic [21:0] SEL0_IDX = 22'h0FFF3E;
  localparam logic [21:0] SEL1_IDX = 22'h0FFF4E;
  localparam logic [21:0] CLKCTL_IDX = 22'h0FFF70;
  localparam logic [21:0] ISC_IDX = 22'h0FFF71;
  // reset values
  localparam logic [7:0] SEL0_RST = 8'h00;
  localparam logic [7:0] SEL1_RST = 8'h00;
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [7:0] ISC_RST = 8'h00;
  // writable bit masks
  localparam logic [7:0] SEL1_MASK = 8'h3F;
  localparam logic [7:0] CLKCTL_MASK = 8'h08;
  localparam logic [7:0] ISC_MASK = 8'h02;
  // field positions
  localparam int CLKCTL_DIV_BIT = 3;
  localparam int ISC_ONE_BIT = 1;
  localparam int SEL1_RTC0_BIT = 4;
  localparam int SEL1_RTC4_BIT = 5;
  // channel layout: unit 0 channels 0..7, unit 1 channels 0..3
  localparam int NUM_CH = 12;
  localparam int LIN_CH = 7;
  // synchroniser lane layout: pins, then lin, fsub, rtc
  localparam int LANE_LIN = 12;
  localparam int LANE_FSUB = 13;
  localparam int LANE_RTC = 14;
  localparam int NUM_LANES = 15;
endpackage : tiss_pkg

// *** hw/tiss_sync_if.sv ***
// tiss_sync_if: raw asynchronous levels in, filtered levels out.
// assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface tiss_sync_if #(parameter int W = 15);
  logic [W-1:0] raw;
  wire [W-1:0] clean;
  modport core_side (output raw, input clean);
  modport sync_side (input raw, output clean);
endinterface : tiss_sync_if
`default_nettype wire

// *** hw/tiss_sync.sv ***
// tiss_sync: three-flop synchroniser with agreement filter per lane.
// assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module tiss_sync #(
  parameter int W = 15
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tiss_sync_if.sync_side sp
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_lane
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic clean_reg;
      logic agree;
      // first flop feeds only the second
      assign agree = (s2_reg == s3_reg);
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          clean_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= sp.raw[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (agree)
            clean_reg <= s3_reg;
        end
      end
      assign sp.clean[g] = clean_reg;
    end
  endgenerate
endmodule : tiss_sync
`default_nettype wire

// *** hw/tiss_top.sv ***
// tiss_top: per-channel timer input source selector with wishbone registers.
// assumes the timer channels sample chan_timer_input_o on clk_i, and that
// pins, lin receive, subsystem clock and rtc interval are asynchronous.
//
// How it works
// - source-select clear routes the channel's own input pin, except channel 7, which takes lin receive when the ISC bit is set.
// - channels 0 and 4 may take rtc interval; rtc with divider set is prohibited.
// - divide-by-2 or 4 comes from bit 3 of system clock control register.
// - both select registers reset to zero and are read/write.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module tiss_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [23:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] chan_input_pin_i,
  input wire logic lin_receive_pin_i,
  input wire logic fsub_clk_i,
  input wire logic rtc_interval_irq_i,
  output logic [11:0] chan_timer_input_o
);
  // every check below lives on clk_i and is quiet during reset, except chk_reset_clear
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  tiss_sync_if #(.W(tiss_pkg::NUM_LANES)) sync_bus ();

  assign sync_bus.raw = {rtc_interval_irq_i, fsub_clk_i, lin_receive_pin_i,
                         chan_input_pin_i};

  tiss_sync #(.W(tiss_pkg::NUM_LANES)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sp(sync_bus.sync_side)
  );

  wire [11:0] pin_clean = sync_bus.clean[11:0];
  wire lin_clean = sync_bus.clean[tiss_pkg::LANE_LIN];
  wire fsub_clean = sync_bus.clean[tiss_pkg::LANE_FSUB];
  wire rtc_clean = sync_bus.clean[tiss_pkg::LANE_RTC];

  // a lane moves only after two flops agree, so a metastable blip is dropped
  chk_lane_zero: assert property (
    $changed(pin_clean[0]) |-> $past(u_sync.g_lane[0].s2_reg)
                               == $past(u_sync.g_lane[0].s3_reg))
    else $error("filtered lane moved without agreement");

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic [7:0] sel0_reg;
  logic [7:0] sel1_reg;
  logic [7:0] clkctl_reg;
  logic [7:0] isc_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  wire [21:0] word_idx = wb_adr_i[23:2];
  wire hit_sel0 = (word_idx == tiss_pkg::SEL0_IDX);
  wire hit_sel1 = (word_idx == tiss_pkg::SEL1_IDX);
  wire hit_clkctl = (word_idx == tiss_pkg::CLKCTL_IDX);
  wire hit_isc = (word_idx == tiss_pkg::ISC_IDX);
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];

  wire [7:0] rd_byte = hit_sel0 ? sel0_reg :
                       hit_sel1 ? sel1_reg :
                       hit_clkctl ? clkctl_reg :
                       hit_isc ? isc_reg : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel0_reg <= tiss_pkg::SEL0_RST;
      sel1_reg <= tiss_pkg::SEL1_RST;
      clkctl_reg <= tiss_pkg::CLKCTL_RST;
      isc_reg <= tiss_pkg::ISC_RST;
    end
    else if (wr_lane0)
    begin
      if (hit_sel0)
        sel0_reg <= wbyte;
      if (hit_sel1)
        sel1_reg <= wbyte & tiss_pkg::SEL1_MASK;
      if (hit_clkctl)
        clkctl_reg <= wbyte & tiss_pkg::CLKCTL_MASK;
      if (hit_isc)
        isc_reg <= wbyte & tiss_pkg::ISC_MASK;
    end
  end

  chk_sel0_write: assert property (
    wr_lane0 && hit_sel0 |=> sel0_reg == $past(wb_dat_i[7:0]))
    else $error("select register 0 write lost");

  chk_sel1_write: assert property (
    wr_lane0 && hit_sel1
    |=> sel1_reg == ($past(wb_dat_i[7:0]) & tiss_pkg::SEL1_MASK))
    else $error("select register 1 write lost");

  chk_sel1_reserved: assert property (
    sel1_reg[7:6] == 2'b00)
    else $error("reserved select bits set");

  // one-wait-state answer; unmapped reads give zero, writes are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= req;
      if (req && !wb_we_i)
        rdata_reg <= {24'h000000, rd_byte};
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  chk_ack_idle: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  chk_rdata_upper: assert property (
    wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  ////////////////////////////////////////////////////////////////////////
  // subsystem clock dividers
  wire div_sel = clkctl_reg[tiss_pkg::CLKCTL_DIV_BIT];
  wire lin_sw = isc_reg[tiss_pkg::ISC_ONE_BIT];
  logic fsub_last_reg;
  logic div2_reg;
  logic div4_reg;

  // dividers count filtered edges, so fsub must stay well below clk_i/8
  wire fsub_rise = fsub_clean && !fsub_last_reg;
  wire div2_rise = fsub_rise && !div2_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fsub_last_reg <= 1'b0;
      div2_reg <= 1'b0;
      div4_reg <= 1'b0;
    end
    else
    begin
      fsub_last_reg <= fsub_clean;
      if (fsub_rise)
        div2_reg <= !div2_reg;
      if (div2_rise)
        div4_reg <= !div4_reg;
    end
  end

  chk_div_toggle: assert property (
    fsub_rise |=> div2_reg != $past(div2_reg))
    else $error("half-rate divider missed an edge");

  ////////////////////////////////////////////////////////////////////////
  // source selection
  // prohibited rtc plus fsub/4 setting drives a quiet low level
  function automatic logic tiss_pick(
    input logic src_sel,
    input logic rtc_sel,
    input logic rtc_ok,
    input logic dsel,
    input logic pin,
    input logic d2,
    input logic d4,
    input logic rtc
  );
    logic res;
    if (!src_sel)
      res = pin;
    else if (rtc_ok && rtc_sel)
      res = dsel ? 1'b0 : rtc;
    else
      res = dsel ? d4 : d2;
    return res;
  endfunction : tiss_pick

  wire [11:0] src_sel_all = {sel1_reg[3:0], sel0_reg};
  wire rtc_sel0 = sel1_reg[tiss_pkg::SEL1_RTC0_BIT];
  wire rtc_sel4 = sel1_reg[tiss_pkg::SEL1_RTC4_BIT];
  wire pin7_src = lin_sw ? lin_clean : pin_clean[tiss_pkg::LIN_CH];
  wire [11:0] pin_src = {pin_clean[11:8], pin7_src, pin_clean[6:0]};
  wire [11:0] pick;
  logic [11:0] out_reg;

  genvar c;
  generate
    for (c = 0; c < tiss_pkg::NUM_CH; c = c + 1)
    begin : g_ch
      localparam bit IS_RTC = (c == 0) || (c == 4);
      wire rsel = (c == 0) ? rtc_sel0 : rtc_sel4;
      assign pick[c] = tiss_pick(src_sel_all[c], rsel, IS_RTC, div_sel,
                                 pin_src[c], div2_reg, div4_reg, rtc_clean);
    end
  endgenerate

  // registered output hides glitches while the select bits change
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_reg <= 12'h000;
    else
      out_reg <= pick;
  end

  assign chan_timer_input_o = out_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence pin0_settled;
    ($stable(chan_input_pin_i[0]) && !sel0_reg[0]) [*8];
  endsequence

  chk_bus_answer: assert property (wb_take |=> wb_answer)
    else $error("wishbone ack not a single cycle after request");

  chk_pin_route: assert property (
    !sel0_reg[1] |=> chan_timer_input_o[1] == $past(pin_clean[1]))
    else $error("pin not routed with select clear");

  chk_pin_unit1: assert property (
    !sel1_reg[3] |=> chan_timer_input_o[11] == $past(pin_clean[11]))
    else $error("unit 1 pin not routed with select clear");

  chk_div_two: assert property (
    sel0_reg[2] && !div_sel |=> chan_timer_input_o[2] == $past(div2_reg))
    else $error("fsub/2 not routed");

  chk_div_four: assert property (
    sel1_reg[0] && div_sel |=> chan_timer_input_o[8] == $past(div4_reg))
    else $error("fsub/4 not routed on unit 1");

  chk_div_four_unit0: assert property (
    sel0_reg[5] && div_sel |=> chan_timer_input_o[5] == $past(div4_reg))
    else $error("fsub/4 not routed on unit 0");

  chk_rtc_route: assert property (
    sel0_reg[4] && rtc_sel4 && !div_sel
    |=> chan_timer_input_o[4] == $past(rtc_clean))
    else $error("rtc interval not routed to channel 4");

  chk_rtc_zero: assert property (
    sel0_reg[0] && rtc_sel0 && !div_sel
    |=> chan_timer_input_o[0] == $past(rtc_clean))
    else $error("rtc interval not routed to channel 0");

  chk_prohibited_low: assert property (
    sel0_reg[0] && rtc_sel0 && div_sel |=> !chan_timer_input_o[0])
    else $error("prohibited setting does not drive low");

  chk_subclock_divider_sel_source: assert property (
    wr_lane0 && hit_clkctl && wb_dat_i[tiss_pkg::CLKCTL_DIV_BIT]
    |=> div_sel && $stable(sel0_reg) && $stable(sel1_reg))
    else $error("divider bit not taken from clock control");

  chk_lin_route: assert property (
    lin_sw && !sel0_reg[7] |=> chan_timer_input_o[7] == $past(lin_clean))
    else $error("lin receive not routed to channel 07");

  chk_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> sel0_reg == 8'h00 && sel1_reg == 8'h00 && out_reg == 12'h000)
    else $error("select registers not cleared by reset");

  chk_sync_path: assert property (
    pin0_settled |-> chan_timer_input_o[0] == chan_input_pin_i[0])
    else $error("settled pin not at output");

endmodule : tiss_top
`default_nettype wire

// *** testbench/tiss_edge_model.sv ***
// tiss_edge_model: stands in for the timer channels' edge detectors.
// assumes the selected inputs are sampled on clk_i.
`timescale 1ns/1ns
`default_nettype none
module tiss_edge_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [11:0] in_i,
  output int cnt_o [12]
);
  logic [11:0] prev_reg;
  // rising edges only, as a capture channel would count them
  always_ff @(posedge clk_i)
  begin
    prev_reg <= in_i;
    for (int c = 0; c < 12; c++)
      cnt_o[c] <= clr_i ? 0 : cnt_o[c] + int'(in_i[c] & ~prev_reg[c]);
  end
endmodule : tiss_edge_model
`default_nettype wire

// *** testbench/tb_tiss_top.sv ***
// tb_tiss_top: self-checking bench for the timer input source selector.
// assumes the design package is compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_tiss_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic lin = 0, fsub = 0, rtc = 0, fen = 0, clr = 0;
  logic [23:0] adr = 24'h000000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic [11:0] pins = 12'h000, outs, prev;
  logic [7:0] q, v;
  logic [21:0] idx [5];
  int cnt [12];
  int failures = 0, total_checks = 0, fdiv = 0, e;
  initial forever #20 clk_i = ~clk_i;
  tiss_top tiss_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .chan_input_pin_i(pins), .lin_receive_pin_i(lin), .fsub_clk_i(fsub),
    .rtc_interval_irq_i(rtc), .chan_timer_input_o(outs));
  tiss_edge_model tiss_edge_model_inst (.clk_i(clk_i), .clr_i(clr),
    .in_i(outs), .cnt_o(cnt));
  // subsystem clock: period 32 clk, slow enough for the filter
  always @(posedge clk_i)
    if (fen)
    begin
      fdiv <= (fdiv == 15) ? 0 : fdiv + 1;
      if (fdiv == 15) fsub <= ~fsub;
    end
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wb(input logic w, input logic [21:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00};
    sel <= 4'hF; wdat <= {24'h000000, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = rdat[7:0];
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  function automatic logic [11:0] ep(logic [11:0] p, logic l, logic s);
    return s ? {p[11:8], l, p[6:0]} : p;
  endfunction : ep
  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end
  initial
  begin
    idx = '{tiss_pkg::SEL0_IDX, tiss_pkg::SEL1_IDX, tiss_pkg::CLKCTL_IDX,
      tiss_pkg::ISC_IDX, 22'h000010};
    void'($urandom(87793));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    foreach (idx[i])
    begin
      wb(0, idx[i], 8'h00);
      check("reset value", q, 8'h00);
    end
    for (int i = 0; i < 3; i++)
    begin
      v = 8'($urandom);
      wb(1, idx[i % 2], v);
      wb(0, idx[i % 2], 8'h00);
      check("readback", rdat,
        {24'h000000, v & (i % 2 ? tiss_pkg::SEL1_MASK : 8'hFF)});
    end
    wb(1, idx[4], 8'hFF);
    wb(0, idx[4], 8'h00);
    check("unmapped", q, 8'h00);
    // select bits clear, other bits set: pins win, except channel 7, which takes lin when isc is set
    wb(1, idx[0], 8'h00);
    wb(1, idx[1], 8'h30);
    wb(1, idx[2], 8'h08);
    for (int i = 0; i < 4; i++)
    begin
      wb(1, idx[3], (i % 2) ? 8'h02 : 8'h00);
      repeat (7) @(posedge clk_i);
      prev = ep(pins, lin, i % 2);
      pins <= 12'($urandom);
      lin <= 1'($urandom);
      repeat (2) @(posedge clk_i);
      check("pin sync", outs, prev);
      repeat (5) @(posedge clk_i);
      check("pin route", outs, ep(pins, lin, i % 2));
    end
    // divided subsystem clock on all channels, rtc select off
    fen <= 1;
    wb(1, idx[0], 8'hFF);
    wb(1, idx[1], 8'h0F);
    for (int d = 0; d < 2; d++)
    begin
      wb(1, idx[2], d ? 8'h08 : 8'h00);
      repeat (200) @(posedge clk_i);
      clr <= 1;
      @(posedge clk_i);
      clr <= 0;
      repeat (2048) @(posedge clk_i);
      e = d ? 16 : 32;
      foreach (cnt[c])
        check("edges", (cnt[c] - e) inside {[-1:1]} ? e : cnt[c], e);
    end
    // rtc interval on channels 0 and 4
    wb(1, idx[1], 8'h3F);
    for (int d = 0; d < 3; d++)
    begin
      wb(1, idx[2], d == 2 ? 8'h08 : 8'h00);
      rtc <= (d != 1);
      repeat (7) @(posedge clk_i);
      check("rtc route", {outs[4], outs[0]}, d == 0 ? 2'b11 : 2'b00);
    end
    summarize();
  end
endmodule : tb_tiss_top
`default_nettype wire
